// ===== hdl/sdmc_init_mode.sv
/*
 device-side init tracker and standard mode register of a low-power ddr
 sdram. watches the command pins, tracks the init steps and their waits,
 holds the mode registers, times read data by cas latency and orders
 burst columns. assumes address and bank pins already synchronous to clock.
*/
`timescale 1ns/100ps
`include "sdmc_consts.svh"
module sdmc_init_mode
   import sdmc_pkg::*;
#(
   parameter int ADDR_W     = 13,
   parameter int COL_W      = 10,
   parameter int PWRUP_CYC  = `SDMC_PWRUP_CYC,
   parameter int ROWPRE_CYC = `SDMC_ROW_PRE_CYC,
   parameter int REFCYC_CYC = `SDMC_REF_CYC_CYC,
   parameter int MODE_CYC   = `SDMC_MODE_DLY_CYC
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              arst_n,
   // command pins from controller
   input  wire logic              clock_enable_pin,
   input  wire logic              chip_sel_n,
   input  wire logic [2:0]        cmd_bits,
   input  wire logic              bank_select_bit0,
   input  wire logic              bank_select_bit1,
   input  wire logic [ADDR_W-1:0] addr_pins,
   // power events
   input  wire logic              deep_power_down,
   // status
   output logic                   init_done,
   output logic                   init_error,
   output logic [ADDR_W-1:0]      mode_value,
   output logic [ADDR_W-1:0]      ext_value,
   output logic [2:0]             burst_length,
   output logic                   burst_type,
   output logic [2:0]             cas_latency,
   output logic                   mode_reserved,
   // read data timing and burst columns
   output logic                   rd_data_start,
   output logic                   beat_valid,
   output logic [COL_W-1:0]       beat_col
);
   sdmc_state_t       st_r, st_nxt;
   logic [31:0]       wait_r, wait_nxt;
   logic [1:0]        ldone_r, ldone_nxt;
   logic              err_r, err_nxt;
   logic [ADDR_W-1:0] mode_r, mode_nxt;
   logic [ADDR_W-1:0] ext_r, ext_nxt;
   logic [2:0]        rdpipe_r, rdpipe_nxt;
   logic              cke_q1, cke_q2;
   logic [2:0]        cmd_q1, cmd_q2;
   logic              cs_q1, cs_q2;
   logic              is_nop, is_pre, is_ref, is_lmr, is_rd, is_wr;

   // command decode, deselect counts as no-op
   function automatic logic cmd_is(input logic [2:0] c, input logic [2:0] k);
      cmd_is = (c == k);
   endfunction : cmd_is

   ////////////////////////////////////////////////////////////////////
   // clock-enable gate and command decode
   always_comb begin
      is_nop = cs_q2 | cmd_is(cmd_q2, `SDMC_CMD_NOP) | !cke_q2;
      is_pre = !is_nop && cmd_is(cmd_q2, `SDMC_CMD_PRE) && addr_pins[10];
      is_ref = !is_nop && cmd_is(cmd_q2, `SDMC_CMD_REF);
      is_lmr = !is_nop && cmd_is(cmd_q2, `SDMC_CMD_LMR) && !bank_select_bit0;
      is_rd  = !is_nop && cmd_is(cmd_q2, `SDMC_CMD_READ);
      is_wr  = !is_nop && cmd_is(cmd_q2, `SDMC_CMD_WRITE);
   end

   // two-stage capture of pins from outside the clock domain
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cke_q1 <= 1'b0;
         cke_q2 <= 1'b0;
         cs_q1  <= 1'b1;
         cs_q2  <= 1'b1;
         cmd_q1 <= `SDMC_CMD_NOP;
         cmd_q2 <= `SDMC_CMD_NOP;
      end else begin
         cke_q1 <= clock_enable_pin;
         cke_q2 <= cke_q1;
         cs_q1  <= chip_sel_n;
         cs_q2  <= cs_q1;
         cmd_q1 <= cmd_bits;
         cmd_q2 <= cmd_q1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // init step tracker and mode register store
   always_comb begin
      st_nxt     = st_r;
      wait_nxt   = (wait_r != 32'h0) ? wait_r - 32'h1 : 32'h0;
      ldone_nxt  = ldone_r;
      err_nxt    = err_r;
      mode_nxt   = mode_r;
      ext_nxt    = ext_r;
      if (!is_nop && wait_r != 32'h0 && st_r != SDMC_READY)
         err_nxt = 1'b1;
      if (is_lmr && wait_r == 32'h0) begin
         if (!bank_select_bit1)
            mode_nxt = addr_pins;
         else
            ext_nxt = addr_pins;
      end
      case (st_r)
         SDMC_PWRUP: begin
            if (is_pre && wait_r == 32'h0) begin
               st_nxt   = SDMC_WPRE;
               wait_nxt = 32'(ROWPRE_CYC);
            end else if (!is_nop && wait_r == 32'h0)
               err_nxt = 1'b1;
         end
         SDMC_WPRE: begin
            if (is_ref && wait_r == 32'h0) begin
               st_nxt   = SDMC_REF1;
               wait_nxt = 32'(REFCYC_CYC);
            end
         end
         SDMC_REF1: begin
            if (is_ref && wait_r == 32'h0) begin
               st_nxt   = SDMC_REF2;
               wait_nxt = 32'(REFCYC_CYC);
            end
         end
         SDMC_REF2, SDMC_MODES: begin
            if (is_lmr && wait_r == 32'h0) begin
               st_nxt    = SDMC_MODES;
               wait_nxt  = 32'(MODE_CYC);
               ldone_nxt = ldone_r | (bank_select_bit1 ? 2'b10 : 2'b01);
            end
            if (ldone_r == 2'b11 && wait_r == 32'h0)
               st_nxt = SDMC_READY;
         end
         SDMC_READY: begin
            if (is_lmr)
               wait_nxt = 32'(MODE_CYC);
         end
         default: st_nxt = SDMC_PWRUP;
      endcase
      if (deep_power_down) begin
         st_nxt    = SDMC_PWRUP;
         wait_nxt  = 32'(PWRUP_CYC);
         ldone_nxt = 2'b00;
         mode_nxt  = `SDMC_MODE_RST;
         ext_nxt   = `SDMC_EXT_RST;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r    <= SDMC_PWRUP;
         wait_r  <= 32'(PWRUP_CYC);
         ldone_r <= 2'b00;
         err_r   <= 1'b0;
         mode_r  <= `SDMC_MODE_RST;
         ext_r   <= `SDMC_EXT_RST;
      end else begin
         st_r    <= st_nxt;
         wait_r  <= wait_nxt;
         ldone_r <= ldone_nxt;
         err_r   <= err_nxt;
         mode_r  <= mode_nxt;
         ext_r   <= ext_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode field decode
   always_comb begin
      burst_length  = mode_r[`SDMC_BL_MSB:`SDMC_BL_LSB];
      burst_type    = mode_r[`SDMC_BT_BIT];
      cas_latency   = mode_r[`SDMC_CL_MSB:`SDMC_CL_LSB];
      mode_reserved = (mode_r[ADDR_W-1:`SDMC_OPM_LSB] != '0)
                    || !(cas_latency inside {3'h2, 3'h3})
                    || !(burst_length inside {3'h1, 3'h2, 3'h3, 3'h4});
      init_done     = (st_r == SDMC_READY);
      init_error    = err_r;
      mode_value    = mode_r;
      ext_value     = ext_r;
   end

   ////////////////////////////////////////////////////////////////////
   // read latency pipe: pulse one cycle before first data edge
   always_comb begin
      rdpipe_nxt = {rdpipe_r[1:0], is_rd && init_done};
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdpipe_r      <= 3'h0;
         rd_data_start <= 1'b0;
      end else begin
         rdpipe_r      <= rdpipe_nxt;
         rd_data_start <= (cas_latency == 3'h2) ? rdpipe_nxt[0] : rdpipe_nxt[1];
      end
   end

   // burst column ordering
   sdmc_burst_seq #(.COL_W(COL_W)) u_seq (
      .clock      (clock),
      .arst_n     (arst_n),
      .start      ((is_rd | is_wr) && init_done),
      .start_col  (addr_pins[COL_W-1:0]),
      .bl_code    (burst_length),
      .interleave (burst_type),
      .beat_valid (beat_valid),
      .beat_col   (beat_col)
   );

   a_mode_store: assert property (@(posedge clock) disable iff (!arst_n)
      (is_lmr && !bank_select_bit1 && wait_r == 32'h0 && !deep_power_down)
      |=> (mode_value == $past(addr_pins)))
      else $error("mode load not stored");
   a_mode_kept: assert property (@(posedge clock) disable iff (!arst_n)
      (!is_lmr && !deep_power_down) |=> $stable(mode_value))
      else $error("mode changed without load");
   a_dpd_reinit: assert property (@(posedge clock) disable iff (!arst_n)
      deep_power_down |=> !init_done)
      else $error("ready after deep power-down");
   a_cl3_timing: assert property (@(posedge clock) disable iff (!arst_n)
      (is_rd && init_done && cas_latency == 3'h3) ##1 $stable(cas_latency) |=> rd_data_start)
      else $error("latency three start wrong");
   a_cl2_timing: assert property (@(posedge clock) disable iff (!arst_n)
      (is_rd && init_done && cas_latency == 3'h2) |=> rd_data_start)
      else $error("latency two start wrong");
   a_ready_path: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(init_done) |-> $past(ldone_r) == 2'b11)
      else $error("ready before both mode loads");
   a_ext_store: assert property (@(posedge clock) disable iff (!arst_n)
      (is_lmr && bank_select_bit1 && wait_r == 32'h0 && !deep_power_down)
      |=> (ext_value == $past(addr_pins)))
      else $error("extended load not stored");
   a_reserved_flag: assert property (@(posedge clock) disable iff (!arst_n)
      (mode_value[ADDR_W-1:`SDMC_OPM_LSB] != '0) |-> mode_reserved)
      else $error("reserved mode not flagged");
endmodule : sdmc_init_mode

// ===== include/sdmc_consts.svh
/*
 constants for the sdram init and mode configuration block: mode field
 positions, command encodings, reset values and wait times.
 assumes a 20 MHz core clock.
*/
`ifndef SDMC_CONSTS_SVH
`define SDMC_CONSTS_SVH

`define SDMC_CLK_MHZ        20
`define SDMC_PWRUP_US       200
`define SDMC_PWRUP_CYC      (`SDMC_PWRUP_US * `SDMC_CLK_MHZ)
`define SDMC_ROW_PRE_NS     30
`define SDMC_ROW_PRE_CYC    ((`SDMC_ROW_PRE_NS * `SDMC_CLK_MHZ + 999) / 1000)
`define SDMC_REF_CYC_NS     110
`define SDMC_REF_CYC_CYC    ((`SDMC_REF_CYC_NS * `SDMC_CLK_MHZ + 999) / 1000)
`define SDMC_MODE_DLY_CYC   2
`define SDMC_BL_LSB         0
`define SDMC_BL_MSB         2
`define SDMC_BT_BIT         3
`define SDMC_CL_LSB         4
`define SDMC_CL_MSB         6
`define SDMC_OPM_LSB        7
`define SDMC_MODE_RST       13'h0032
`define SDMC_EXT_RST        13'h0000
`define SDMC_CMD_NOP        3'h7
`define SDMC_CMD_PRE        3'h2
`define SDMC_CMD_REF        3'h1
`define SDMC_CMD_LMR        3'h0
`define SDMC_CMD_READ       3'h5
`define SDMC_CMD_WRITE      3'h4

`endif

// ===== include/sdmc_pkg.sv
/*
 types for the sdram init and mode configuration block.
 assumes sdmc_consts.svh for all numeric values except the state encodings, which are set here.
*/
package sdmc_pkg;
   typedef enum logic [5:0] {
      SDMC_PWRUP = 6'h01,
      SDMC_WPRE  = 6'h02,
      SDMC_REF1  = 6'h04,
      SDMC_REF2  = 6'h08,
      SDMC_MODES = 6'h10,
      SDMC_READY = 6'h20
   } sdmc_state_t;
endpackage : sdmc_pkg

// ===== hdl/sdmc_burst_seq.sv
/*
 burst column sequencer: gives the column of each beat of a burst from
 start column, burst length code and burst type.
 assumes mode fields come already decoded from the main block.
*/
`timescale 1ns/100ps
`include "sdmc_consts.svh"
module sdmc_burst_seq
   import sdmc_pkg::*;
#(
   parameter int COL_W = 10
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             arst_n,
   // burst start
   input  wire logic             start,
   input  wire logic [COL_W-1:0] start_col,
   input  wire logic [2:0]       bl_code,
   input  wire logic             interleave,
   // column out
   output logic                  beat_valid,
   output logic [COL_W-1:0]      beat_col
);
   logic [COL_W-1:0] base_r, base_nxt;
   logic [3:0]       cnt_r, cnt_nxt;
   logic [3:0]       low_r, low_nxt;
   logic             run_r, run_nxt;
   logic [3:0]       mask_r, mask_nxt;
   logic [3:0]       lowc;

   // length code to low-bit mask
   function automatic logic [3:0] len_mask(input logic [2:0] c);
      case (c)
         3'h1: len_mask = 4'h1;
         3'h2: len_mask = 4'h3;
         3'h3: len_mask = 4'h7;
         3'h4: len_mask = 4'hF;
         default: len_mask = 4'h1;
      endcase
   endfunction : len_mask

   ////////////////////////////////////////////////////////////////////
   // beat order: wrap in aligned block, sequential or xor
   always_comb begin
      if (interleave)
         lowc = (low_r ^ cnt_r) & mask_r;
      else
         lowc = (low_r + cnt_r) & mask_r;
      base_nxt = base_r;
      low_nxt  = low_r;
      mask_nxt = mask_r;
      cnt_nxt  = cnt_r;
      run_nxt  = run_r;
      if (start) begin
         mask_nxt = len_mask(bl_code);
         base_nxt = start_col & ~{{(COL_W-4){1'b0}}, len_mask(bl_code)};
         low_nxt  = start_col[3:0] & len_mask(bl_code);
         cnt_nxt  = 4'h0;
         run_nxt  = 1'b1;
      end else if (run_r) begin
         cnt_nxt = cnt_r + 4'h1;
         if (cnt_r == mask_r)
            run_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         base_r <= '0;
         low_r  <= 4'h0;
         mask_r <= 4'h1;
         cnt_r  <= 4'h0;
         run_r  <= 1'b0;
         beat_valid <= 1'b0;
         beat_col   <= '0;
      end else begin
         base_r <= base_nxt;
         low_r  <= low_nxt;
         mask_r <= mask_nxt;
         cnt_r  <= cnt_nxt;
         run_r  <= run_nxt;
         beat_valid <= run_r;
         beat_col   <= base_r | {{(COL_W-4){1'b0}}, lowc};
      end
   end

   a_beat_in_block: assert property (@(posedge clock) disable iff (!arst_n)
      run_r |-> ((base_r & {{(COL_W-4){1'b0}}, mask_r}) == '0))
      else $error("burst base not aligned");
endmodule : sdmc_burst_seq

// ===== verification/sdmc_ctrl_model.sv
/*
 controller model facing the init and mode block: drives cke, select,
 command, bank and address pins with tasks for single commands and the
 full init sequence.
 assumes the bench calls its tasks and that the clock is free running.
*/
`timescale 1ns/100ps
`include "sdmc_consts.svh"
module sdmc_ctrl_model #(
   parameter int PWRUP_CYC  = 20,
   parameter int ROWPRE_CYC = 1,
   parameter int REFCYC_CYC = 3,
   parameter int MODE_CYC   = 2
) (
   // clock
   input  wire logic  clock,
   // pins toward the device
   output logic        clock_enable_pin,
   output logic        chip_sel_n,
   output logic [2:0]  cmd_bits,
   output logic        bank_select_bit0,
   output logic        bank_select_bit1,
   output logic [12:0] addr_pins
);
   ////////////////////////////////////////////////////////////////
   // idle pins at time zero, cke high before the clock runs
   initial begin
      clock_enable_pin = 1'b1;
      chip_sel_n       = 1'b0;
      cmd_bits         = `SDMC_CMD_NOP;
      bank_select_bit0 = 1'b0;
      bank_select_bit1 = 1'b0;
      addr_pins        = 13'h0000;
   end

   ////////////////////////////////////////////////////////////////
   // nop cycles
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask : idle

   // cke and select levels
   task automatic select(input logic cke, input logic cs_n);
      @(negedge clock);
      clock_enable_pin = cke;
      chip_sel_n       = cs_n;
   endtask : select

   // one command; bank and address held until the device acts on them
   task automatic issue(input logic [2:0] c, input logic b1, input logic [12:0] a);
      @(negedge clock);
      cmd_bits         = c;
      bank_select_bit0 = 1'b0;
      bank_select_bit1 = b1;
      addr_pins        = a;
      @(negedge clock);
      cmd_bits = `SDMC_CMD_NOP;
      repeat (2) @(negedge clock);
      // hold over: stop showing the old value
      addr_pins        = ~a;
      bank_select_bit0 = 1'b1;
      bank_select_bit1 = ~b1;
   endtask : issue

   // full init with cycle-counted waits, mode loads in either order
   task automatic init_seq(input logic [12:0] mode, input logic [12:0] ext, input logic ext_first);
      idle(PWRUP_CYC + 2);
      issue(`SDMC_CMD_PRE, 1'b0, 13'h0400);
      idle(ROWPRE_CYC);
      repeat (2) begin
         issue(`SDMC_CMD_REF, 1'b0, 13'h0000);
         idle(REFCYC_CYC);
      end
      issue(`SDMC_CMD_LMR, ext_first, ext_first ? ext : mode);
      idle(MODE_CYC);
      issue(`SDMC_CMD_LMR, !ext_first, ext_first ? mode : ext);
      // ready flag rises one clock after the last wait has run out
      idle(MODE_CYC + 1);
   endtask : init_seq
endmodule : sdmc_ctrl_model

// ===== verification/sdmc_init_mode_bench.sv
/*
 self-checking bench for the init and mode block: init order, mode and
 extended loads, reserved flags, read latency, burst column order.
 assumes the controller model drives all command pins.
*/
`timescale 1ns/100ps
`include "sdmc_consts.svh"
module sdmc_init_mode_bench;
   import sdmc_pkg::*;
   localparam int PW = 20;
   localparam int RP = 1;
   localparam int RF = 3;
   localparam int MD = 2;
   logic clock, arst_n, deep_power_down, clock_enable_pin, chip_sel_n;
   logic bank_select_bit0, bank_select_bit1, init_done, init_error, burst_type;
   logic mode_reserved, rd_data_start, beat_valid;
   logic [2:0]  cmd_bits, burst_length, cas_latency;
   logic [12:0] addr_pins, mode_value, ext_value, m, e;
   logic [9:0]  beat_col;
   int err_count, comparisons, seed, cl, bt, code;

   ////////////////////////////////////////////////////////////////
   // clock and watchdog
   always #25 clock = ~clock;
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      stop_test();
   end

   sdmc_ctrl_model #(.PWRUP_CYC(PW), .ROWPRE_CYC(RP), .REFCYC_CYC(RF), .MODE_CYC(MD)) ctl (
      .clock(clock), .clock_enable_pin(clock_enable_pin), .chip_sel_n(chip_sel_n),
      .cmd_bits(cmd_bits), .bank_select_bit0(bank_select_bit0),
      .bank_select_bit1(bank_select_bit1), .addr_pins(addr_pins));

   sdmc_init_mode #(.PWRUP_CYC(PW), .ROWPRE_CYC(RP), .REFCYC_CYC(RF), .MODE_CYC(MD)) uut (
      .clock(clock), .arst_n(arst_n), .clock_enable_pin(clock_enable_pin),
      .chip_sel_n(chip_sel_n), .cmd_bits(cmd_bits), .bank_select_bit0(bank_select_bit0),
      .bank_select_bit1(bank_select_bit1), .addr_pins(addr_pins),
      .deep_power_down(deep_power_down), .init_done(init_done), .init_error(init_error),
      .mode_value(mode_value), .ext_value(ext_value), .burst_length(burst_length),
      .burst_type(burst_type), .cas_latency(cas_latency), .mode_reserved(mode_reserved),
      .rd_data_start(rd_data_start), .beat_valid(beat_valid), .beat_col(beat_col));

   ////////////////////////////////////////////////////////////////
   // expected column of beat i
   function automatic logic [9:0] exp_col(input logic [9:0] s, input int c, input logic il, input int i);
      logic [9:0] msk;
      msk = (10'h001 << c) - 10'h001;
      return (s & ~msk) | ((il ? (s ^ 10'(i)) : (s + 10'(i))) & msk);
   endfunction : exp_col

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // read or write with watch window on pulse position and beat columns
   task automatic do_read(input logic [9:0] col, input int c, input logic il, input int lat, input bit live,
                          input bit wr);
      int rd_at;
      int np;
      int nb;
      rd_at = -1;
      np = 0;
      nb = 0;
      fork
         ctl.issue(wr ? `SDMC_CMD_WRITE : `SDMC_CMD_READ, 1'b0, {3'h0, col});
         for (int k = 0; k < 40; k++) begin
            @(negedge clock);
            if (rd_data_start === 1'b1) begin
               rd_at = k;
               np++;
            end
            if (beat_valid === 1'b1) begin
               chk(beat_col, exp_col(col, c, il, nb));
               nb++;
            end
         end
      join
      chk(np, (live && !wr) ? 1 : 0);
      chk(nb, live ? (1 << c) : 0);
      // pins set at k=0, two capture stages, then latency less one
      if (live && !wr)
         chk(rd_at, lat + 1);
   endtask : do_read

   // counts and verdict
   task automatic stop_test();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      deep_power_down = 1'b0;
      seed = 32'hF493;
      err_count = 0;
      comparisons = 0;
      repeat (12) @(negedge clock);
      arst_n = 1'b1;
      ctl.issue(`SDMC_CMD_REF, 1'b0, 13'h0000);
      ctl.idle(4);
      chk(init_error, 1'b1);
      chk(init_done, 1'b0);
      $display("test early_command done");
      arst_n = 1'b0;
      ctl.idle(2);
      chk({init_error, init_done}, 2'h0);
      chk(mode_value, `SDMC_MODE_RST);
      chk(ext_value, `SDMC_EXT_RST);
      arst_n = 1'b1;
      m = 13'h0022;
      e = 13'($random(seed));
      ctl.init_seq(m, e, 1'b0);
      chk({init_error, init_done}, 2'h1);
      chk(mode_value, m);
      chk(ext_value, e);
      $display("test init_std_first done");
      for (cl = 2; cl <= 3; cl++)
         for (bt = 0; bt < 2; bt++)
            for (code = 1; code <= 4; code++) begin
               m = {6'h00, cl[2:0], bt[0], code[2:0]};
               ctl.issue(`SDMC_CMD_LMR, 1'b0, m);
               ctl.idle(MD);
               chk(mode_value, m);
               chk({cas_latency, burst_type, burst_length}, m[6:0]);
               chk(mode_reserved, 1'b0);
               repeat (2) do_read(10'($random(seed)), code, bt[0], cl, 1'b1, 1'b0);
            end
      $display("test burst_latency done");
      ctl.issue(`SDMC_CMD_LMR, 1'b0, 13'($random(seed)) | 13'h0080);
      ctl.idle(MD);
      chk(mode_reserved, 1'b1);
      ctl.issue(`SDMC_CMD_LMR, 1'b0, m);
      ctl.idle(MD);
      e = 13'($random(seed));
      ctl.issue(`SDMC_CMD_LMR, 1'b1, e);
      ctl.idle(MD);
      chk(ext_value, e);
      chk(mode_value, m);
      ctl.select(1'b1, 1'b1);
      do_read(10'h005, 4, 1'b1, 3, 1'b0, 1'b0);
      ctl.select(1'b0, 1'b0);
      do_read(10'h00A, 4, 1'b1, 3, 1'b0, 1'b0);
      ctl.select(1'b1, 1'b0);
      $display("test reserved_ext_refused done");
      deep_power_down = 1'b1;
      ctl.idle(3);
      deep_power_down = 1'b0;
      ctl.idle(1);
      chk(init_done, 1'b0);
      chk(mode_value, `SDMC_MODE_RST);
      m = 13'h003B;
      e = 13'($random(seed));
      ctl.init_seq(m, e, 1'b1);
      chk({init_error, init_done}, 2'h1);
      chk(mode_value, m);
      chk(ext_value, e);
      do_read(10'h3FD, 3, 1'b1, 3, 1'b1, 1'b0);
      do_read(10'h2C6, 3, 1'b1, 3, 1'b1, 1'b1);
      $display("test deep_power_down done");
      stop_test();
   end
endmodule : sdmc_init_mode_bench
